// [design/tsq_regs.vh]
// Purpose: Constants for the touch status query responder
// Assumes: APB byte addresses, 32-bit data
// Notes:   Offsets chosen for this block
`ifndef TSQ_REGS_VH
`define TSQ_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TSQ_CTRL_OFF     8'h00
`define TSQ_SCOPE_OFF    8'h04
`define TSQ_WINDOW_OFF   8'h08
`define TSQ_KEYWR_OFF    8'h0C
`define TSQ_STATUS_OFF   8'h10
`define TSQ_NVWR_OFF     8'h14
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define TSQ_CTRL_SYNC_BIT  0
`define TSQ_SCOPE_MODE_LSB 8
`define TSQ_SCOPE_RST      10'h000
`define TSQ_WIN_LO_RST     8'h40
`define TSQ_WIN_HI_RST     8'hBF
`define TSQ_KEYWR_FLD_LSB  8
`define TSQ_KEYWR_VAL_LSB  16
`define TSQ_NVWR_DAT_LSB   8
// ----------------------------------------
// Scope modes
// ----------------------------------------
`define TSQ_SC_ALL   2'h0
`define TSQ_SC_KEY   2'h1
`define TSQ_SC_ROW   2'h2
`define TSQ_SC_COL   2'h3
// ----------------------------------------
// Key data fields written by acquisition
// ----------------------------------------
`define TSQ_F_SIG    3'h0
`define TSQ_F_REF    3'h1
`define TSQ_F_LAD    3'h2
`define TSQ_F_CZ     3'h3
`define TSQ_F_INT    3'h4
`define TSQ_F_DET    3'h5
`define TSQ_F_RCST   3'h6
`define TSQ_F_RCRES  3'h7
// ----------------------------------------
// Query codes and limits
// ----------------------------------------
`define TSQ_Q_CZ     8'h34
`define TSQ_Q_INT    8'h35
`define TSQ_Q_CSUM   8'h36
`define TSQ_Q_STAT   8'h37
`define TSQ_Q_GSIG   8'h20
`define TSQ_Q_GDEL   8'h21
`define TSQ_Q_GREF   8'h22
`define TSQ_Q_GLAD   8'h23
`define TSQ_Q_GCZ    8'h24
`define TSQ_Q_GINT   8'h25
`define TSQ_Q_ERR    8'h65
`define TSQ_Q_GERR   8'h45
`define TSQ_DRIFT_HI 8'hBF
`define TSQ_DRIFT_LO 8'h40
`define TSQ_RC_TRIES 3'h5
`define TSQ_GRP_BIG  7'h40
`define TSQ_GRP_SML  7'h08
`endif

// [design/tsq_responder.v]
// Purpose: Status query answering over the SPI slave link, key data over APB
// Assumes: SPI mode 0, MSB first, sclk far slower than pclk
// Notes:   Link pins pass two flip-flops before any logic reads them
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "tsq_regs.vh"
// Operation
// - Query 0x34 returns scoped key cancel_cap state, 2 means both caps in
// - Query 0x35 returns scoped key detection integrator count
// - Query 0x36 returns 8-bit carry fold-back sum of setup store
// - Checksum is only refreshed by a reset
// - Query 0x37 returns detect, recal, error, sync fail, nvm mismatch bits
// - Status bits 5 to 7 read zero
// - Sync fail only when external sync enabled and not locked
// - Query 0x20 returns signals, 8 for row or column, else 64
// - Query 0x21 returns group deltas, 8 or 64 bytes
// - Query 0x22 returns group references, 8 or 64 bytes
// - Query 0x23 returns group resistor_ladder offsets, 8 or 64 bytes
// - Query 0x24 returns group cancel_cap states 0..3, 8 or 64 bytes
// - Query 0x25 returns group integrator counts, 8 or 64 bytes
// - Query 0x65 returns key error nibble fail, recal, high, low
// - Forced recal retries five times before setting fail flag
// - Recal flag setting clears high and low flags at once
// - High flag on reference above 191 or above upper window
// - Low flag on reference below 64 or below lower window
// - Query 0x45 returns 1 byte for a key, 8 for a group
// - Matrix error report: byte per column, bit n is row n
// - Queries answered regardless of get or put mode
// - Scope resets to all keys and holds until changed
// - Key index is row plus eight times column
module tsq_responder (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        spi_sclk,
   input  wire        spi_cs_n,
   input  wire        spi_mosi,
   output reg         spi_miso,
   output reg         spi_miso_oe,
   input  wire        sync_locked,
   input  wire        nvm_mismatch
);

// ----------------------------------------
// Functions
// ----------------------------------------
function [5:0] key_at;
   input [2:0] row;
   input [2:0] col;
   key_at = {col, row};
endfunction

// ----------------------------------------
// Storage
// ----------------------------------------
reg  [7:0]  sig_mem [0:63];
reg  [7:0]  ref_mem [0:63];
reg  [7:0]  lad_mem [0:63];
reg  [1:0]  cz_mem  [0:63];
reg  [7:0]  int_mem [0:63];
reg  [2:0]  try_mem [0:63];
reg  [7:0]  nv_mem  [0:63];
reg  [63:0] det_r;
reg  [63:0] fail_r;
reg  [63:0] rcal_r;
reg  [63:0] hi_r;
reg  [63:0] lo_r;
reg         sync_en_r;
reg  [9:0]  scope_r;
reg  [7:0]  win_lo_r;
reg  [7:0]  win_hi_r;
reg  [7:0]  csum_r;
reg  [6:0]  cs_idx_r;
reg  [1:0]  sclk_s;
reg  [1:0]  cs_s;
reg  [1:0]  mosi_s;
reg  [1:0]  lock_s;
reg  [1:0]  mism_s;
reg         sclk_d;
reg  [2:0]  bit_cnt_r;
reg  [7:0]  rx_sh_r;
reg  [7:0]  tx_sh_r;
reg         skip_r;
reg  [7:0]  cmd_r;
reg  [6:0]  idx_r;
reg  [6:0]  len_r;
reg  [7:0]  tx_byte;
reg  [7:0]  stat_byte;
reg  [6:0]  grp_len;
reg  [5:0]  gkey;
reg  [7:0]  err_row;
reg  [7:0]  sum9;
integer     n;

wire        wr_en   = psel & penable & pwrite;
wire        mapped  = (paddr == `TSQ_CTRL_OFF) | (paddr == `TSQ_SCOPE_OFF) |
                      (paddr == `TSQ_WINDOW_OFF) | (paddr == `TSQ_KEYWR_OFF) |
                      (paddr == `TSQ_STATUS_OFF) | (paddr == `TSQ_NVWR_OFF);
wire [1:0]  sc_mode = scope_r[`TSQ_SCOPE_MODE_LSB+1:`TSQ_SCOPE_MODE_LSB];
wire [2:0]  sc_row  = scope_r[2:0];
wire [2:0]  sc_col  = scope_r[5:3];
wire [5:0]  sc_key  = key_at(sc_row, sc_col);
wire [5:0]  kw_key  = pwdata[5:0];
wire [2:0]  kw_fld  = pwdata[`TSQ_KEYWR_FLD_LSB+2:`TSQ_KEYWR_FLD_LSB];
wire [7:0]  kw_val  = pwdata[`TSQ_KEYWR_VAL_LSB+7:`TSQ_KEYWR_VAL_LSB];
wire        kw_en   = wr_en & (paddr == `TSQ_KEYWR_OFF);
wire        csum_ok = cs_idx_r[6];
wire        rise    = sclk_s[1] & ~sclk_d;
wire        fall    = ~sclk_s[1] & sclk_d;
wire        in_frm  = ~cs_s[1];
wire [7:0]  rx_byte = {rx_sh_r[6:0], mosi_s[1]};
wire [8:0]  csum_add = {1'b0, csum_r} + {1'b0, nv_mem[cs_idx_r[5:0]]};

assign pready  = 1'b1;
assign pslverr = psel & penable & ~mapped;

// ----------------------------------------
// Status byte and group sizing
// ----------------------------------------
always @* begin
   stat_byte    = 8'h00;
   stat_byte[0] = |det_r;
   stat_byte[1] = |rcal_r;
   stat_byte[2] = |(fail_r | rcal_r | hi_r | lo_r);
   stat_byte[3] = sync_en_r & ~lock_s[1];
   stat_byte[4] = mism_s[1];
   // Key scope is no group scope, so groups fall back to the matrix
   if (sc_mode == `TSQ_SC_ROW || sc_mode == `TSQ_SC_COL)
      grp_len = `TSQ_GRP_SML;
   else
      grp_len = `TSQ_GRP_BIG;
end

// ----------------------------------------
// Answer byte for the current position
// ----------------------------------------
always @* begin
   // Group members walk upward in key index
   case (sc_mode)
      `TSQ_SC_ROW: gkey = key_at(sc_row, idx_r[2:0]);
      `TSQ_SC_COL: gkey = key_at(idx_r[2:0], sc_col);
      default:     gkey = idx_r[5:0];
   endcase
   err_row = 8'h00;
   for (n = 0; n < 8; n = n + 1) begin
      case (sc_mode)
         `TSQ_SC_ROW: err_row[n] = fail_r[{n[2:0], sc_row}] | rcal_r[{n[2:0], sc_row}] |
                                   hi_r[{n[2:0], sc_row}] | lo_r[{n[2:0], sc_row}];
         `TSQ_SC_COL: err_row[n] = fail_r[{sc_col, n[2:0]}] | rcal_r[{sc_col, n[2:0]}] |
                                   hi_r[{sc_col, n[2:0]}] | lo_r[{sc_col, n[2:0]}];
         default:     err_row[n] = fail_r[{idx_r[2:0], n[2:0]}] |
                                   rcal_r[{idx_r[2:0], n[2:0]}] |
                                   hi_r[{idx_r[2:0], n[2:0]}] | lo_r[{idx_r[2:0], n[2:0]}];
      endcase
   end
   case (cmd_r)
      `TSQ_Q_CZ:   tx_byte = {6'h00, cz_mem[sc_key]};
      `TSQ_Q_INT:  tx_byte = int_mem[sc_key];
      `TSQ_Q_CSUM: tx_byte = csum_r;
      `TSQ_Q_STAT: tx_byte = stat_byte;
      `TSQ_Q_GSIG: tx_byte = sig_mem[gkey];
      `TSQ_Q_GDEL: tx_byte = (sig_mem[gkey] > ref_mem[gkey]) ? 8'h00 :
                             ref_mem[gkey] - sig_mem[gkey];
      `TSQ_Q_GREF: tx_byte = ref_mem[gkey];
      `TSQ_Q_GLAD: tx_byte = lad_mem[gkey];
      `TSQ_Q_GCZ:  tx_byte = {6'h00, cz_mem[gkey]};
      `TSQ_Q_GINT: tx_byte = int_mem[gkey];
      `TSQ_Q_ERR:  tx_byte = {4'h0, lo_r[sc_key], hi_r[sc_key],
                              rcal_r[sc_key], fail_r[sc_key]};
      `TSQ_Q_GERR: tx_byte = (sc_mode == `TSQ_SC_KEY) ?
                             {4'h0, lo_r[sc_key], hi_r[sc_key],
                              rcal_r[sc_key], fail_r[sc_key]} : err_row;
      default:     tx_byte = 8'h00;
   endcase
end

// ----------------------------------------
// APB registers
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      sync_en_r <= 1'b0;
      scope_r   <= `TSQ_SCOPE_RST;
      win_lo_r  <= `TSQ_WIN_LO_RST;
      win_hi_r  <= `TSQ_WIN_HI_RST;
   end else if (wr_en) begin
      case (paddr)
         `TSQ_CTRL_OFF:   sync_en_r <= pwdata[`TSQ_CTRL_SYNC_BIT];
         `TSQ_SCOPE_OFF:  scope_r   <= pwdata[9:0];
         `TSQ_WINDOW_OFF: begin
            win_lo_r <= pwdata[7:0];
            win_hi_r <= pwdata[15:8];
         end
         default: ;
      endcase
   end
end

always @* begin
   case (paddr)
      `TSQ_CTRL_OFF:   prdata = {31'h0000_0000, sync_en_r};
      `TSQ_SCOPE_OFF:  prdata = {22'h00_0000, scope_r};
      `TSQ_WINDOW_OFF: prdata = {16'h0000, win_hi_r, win_lo_r};
      `TSQ_STATUS_OFF: prdata = {15'h0000, csum_ok, csum_r, stat_byte};
      default:         prdata = 32'h0000_0000;
   endcase
end

// ----------------------------------------
// Setup store and checksum
// ----------------------------------------
// The store keeps contents across reset; only the sum restarts
always @(posedge pclk) begin
   if (wr_en && paddr == `TSQ_NVWR_OFF)
      nv_mem[pwdata[5:0]] <= pwdata[`TSQ_NVWR_DAT_LSB+7:`TSQ_NVWR_DAT_LSB];
end

always @* begin
   sum9 = csum_add[7:0] + {7'h00, csum_add[8]};
end

// Sum walks the store once after reset, later writes go unseen
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      csum_r   <= 8'h00;
      cs_idx_r <= 7'h00;
   end else if (!csum_ok) begin
      csum_r   <= sum9;
      cs_idx_r <= cs_idx_r + 7'h01;
   end
end

// ----------------------------------------
// Key data and error flags
// ----------------------------------------
always @(posedge pclk) begin
   if (kw_en) begin
      case (kw_fld)
         `TSQ_F_SIG: sig_mem[kw_key] <= kw_val;
         `TSQ_F_REF: ref_mem[kw_key] <= kw_val;
         `TSQ_F_LAD: lad_mem[kw_key] <= kw_val;
         `TSQ_F_CZ:  cz_mem[kw_key]  <= kw_val[1:0];
         `TSQ_F_INT: int_mem[kw_key] <= kw_val;
         `TSQ_F_RCST: try_mem[kw_key] <= 3'h0;
         `TSQ_F_RCRES: begin
            if (!kw_val[0])
               try_mem[kw_key] <= try_mem[kw_key] + 3'h1;
         end
         default: ;
      endcase
   end
end

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      det_r  <= 64'h0000_0000_0000_0000;
      fail_r <= 64'h0000_0000_0000_0000;
      rcal_r <= 64'h0000_0000_0000_0000;
      hi_r   <= 64'h0000_0000_0000_0000;
      lo_r   <= 64'h0000_0000_0000_0000;
   end else if (kw_en) begin
      case (kw_fld)
         `TSQ_F_DET: det_r[kw_key] <= kw_val[0];
         `TSQ_F_REF: begin
            // Drift checks only while no recal owns the key
            if (!rcal_r[kw_key]) begin
               if (kw_val > `TSQ_DRIFT_HI)
                  hi_r[kw_key] <= 1'b1;
               if (kw_val < `TSQ_DRIFT_LO)
                  lo_r[kw_key] <= 1'b1;
            end
         end
         `TSQ_F_RCST: begin
            rcal_r[kw_key] <= 1'b1;
            hi_r[kw_key]   <= 1'b0;
            lo_r[kw_key]   <= 1'b0;
         end
         `TSQ_F_RCRES: begin
            if (rcal_r[kw_key]) begin
               if (kw_val[0]) begin
                  rcal_r[kw_key] <= 1'b0;
                  fail_r[kw_key] <= 1'b0;
                  hi_r[kw_key]   <= (ref_mem[kw_key] > win_hi_r);
                  lo_r[kw_key]   <= (ref_mem[kw_key] < win_lo_r);
               end else if (try_mem[kw_key] == `TSQ_RC_TRIES - 3'h1) begin
                  rcal_r[kw_key] <= 1'b0;
                  fail_r[kw_key] <= 1'b1;
               end
            end
         end
         default: ;
      endcase
   end
end

// ----------------------------------------
// Link synchronisers
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      sclk_s <= 2'b00;
      cs_s   <= 2'b11;
      mosi_s <= 2'b00;
      lock_s <= 2'b00;
      mism_s <= 2'b00;
      sclk_d <= 1'b0;
   end else begin
      sclk_s <= {sclk_s[0], spi_sclk};
      cs_s   <= {cs_s[0], spi_cs_n};
      mosi_s <= {mosi_s[0], spi_mosi};
      lock_s <= {lock_s[0], sync_locked};
      mism_s <= {mism_s[0], nvm_mismatch};
      sclk_d <= sclk_s[1];
   end
end

// ----------------------------------------
// SPI byte engine
// ----------------------------------------
// No mode state is consulted: get and put answer alike
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      bit_cnt_r   <= 3'h0;
      rx_sh_r     <= 8'h00;
      tx_sh_r     <= 8'h00;
      skip_r      <= 1'b0;
      cmd_r       <= 8'h00;
      idx_r       <= 7'h00;
      len_r       <= 7'h00;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
   end else if (!in_frm) begin
      // Frame end drops any answer still pending
      bit_cnt_r   <= 3'h0;
      skip_r      <= 1'b0;
      len_r       <= 7'h00;
      tx_sh_r     <= 8'h00;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
   end else begin
      spi_miso_oe <= 1'b1;
      if (rise) begin
         rx_sh_r   <= rx_byte;
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (bit_cnt_r == 3'h7) begin
            skip_r <= 1'b1;
            if (len_r != 7'h00) begin
               // Host bytes during an answer are ignored
               spi_miso <= tx_byte[7];
               tx_sh_r  <= {tx_byte[6:0], 1'b0};
               idx_r    <= idx_r + 7'h01;
               len_r    <= len_r - 7'h01;
            end else begin
               cmd_r    <= rx_byte;
               idx_r    <= 7'h00;
               spi_miso <= 1'b0;
               tx_sh_r  <= 8'h00;
               case (rx_byte)
                  `TSQ_Q_GSIG, `TSQ_Q_GDEL, `TSQ_Q_GREF,
                  `TSQ_Q_GLAD, `TSQ_Q_GCZ, `TSQ_Q_GINT:
                     len_r <= grp_len;
                  `TSQ_Q_GERR:
                     len_r <= (sc_mode == `TSQ_SC_KEY) ? 7'h01 : `TSQ_GRP_SML;
                  `TSQ_Q_CZ, `TSQ_Q_INT, `TSQ_Q_CSUM, `TSQ_Q_STAT, `TSQ_Q_ERR:
                     len_r <= 7'h01;
                  default:
                     len_r <= 7'h00;
               endcase
            end
         end
      end else if (fall) begin
         if (skip_r)
            skip_r <= 1'b0;
         else begin
            spi_miso <= tx_sh_r[7];
            tx_sh_r  <= {tx_sh_r[6:0], 1'b0};
         end
      end
   end
end

endmodule

// [tb/tb.sv]
// Purpose: Self-checking bench for the status query responder
// Assumes: APB master and SPI host model drive the block
// Notes:   Expected values come from bench side key tables
`timescale 1ns/10ps
`include "tsq_regs.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
   $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
   logic [7:0]  paddr, ck;
   logic [31:0] pwdata, prdata, q;
   logic        sclk, cs_n, mosi, miso, miso_oe, lk, mm;
   logic [7:0]  sg[64], rf[64], ld[64], cz[64], it[64], nv[64];
   logic [63:0] em;
   logic [2:0]  x;
   int          num_errors, total_checks, cyc, k;
   tsq_responder u_tsq_responder (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
      .spi_miso(miso), .spi_miso_oe(miso_oe), .sync_locked(lk), .nvm_mismatch(mm));
   tsq_spi_host u_tsq_spi_host (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
      .spi_miso(miso));
   initial pclk = 1'b0;
   always #2.5 pclk = ~pclk;
   // Hang guard, well above the expected run length
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 80000) begin
         `CHK(cyc, 0)
         complete_run();
      end
   end
   // ----------------------------------------
   // Tasks and expectations
   // ----------------------------------------
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   task automatic kw(input int n, input logic [2:0] f, input logic [7:0] v);
      wr(`TSQ_KEYWR_OFF, {8'h00, v, 5'h00, f, 2'h0, 6'(n)});
   endtask
   task automatic rst();
      int t;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t = 0;
      do begin
         rd(`TSQ_STATUS_OFF);
         t++;
      end while (q[16] !== 1'b1 && t < 100);
   endtask
   function automatic logic [7:0] fold();
      logic [8:0] s;
      s = 9'h000;
      for (int i = 0; i < 64; i++) begin
         s = s[7:0] + nv[i];
         s = s[7:0] + s[8];
      end
      return s[7:0];
   endfunction
   function automatic logic [7:0] fv(input logic [7:0] c, input int n);
      case (c)
         8'h20: fv = sg[n];
         8'h21: fv = (rf[n] > sg[n]) ? rf[n] - sg[n] : 8'h00;
         8'h22: fv = rf[n];
         8'h23: fv = ld[n];
         8'h24: fv = cz[n];
         default: fv = it[n];
      endcase
   endfunction
   task automatic grp(input logic [7:0] c, input logic [1:0] m, input logic [2:0] s);
      int n, j;
      n = (m == `TSQ_SC_ROW || m == `TSQ_SC_COL) ? 8 : 64;
      wr(`TSQ_SCOPE_OFF, {22'h0, m, 2'h0, s, s});
      u_tsq_spi_host.xfer(c, n);
      for (int i = 0; i < n; i++) begin
         j = (m == `TSQ_SC_ROW) ? s + 8 * i : (m == `TSQ_SC_COL) ? i + 8 * s : i;
         `CHK(u_tsq_spi_host.rx[i], fv(c, j))
      end
   endtask
   task automatic ek(input int n, input logic [3:0] e);
      wr(`TSQ_SCOPE_OFF, 32'h0000_0100 | n);
      u_tsq_spi_host.xfer(`TSQ_Q_ERR, 1);
      `CHK(u_tsq_spi_host.rx[0][3:0], e)
   endtask
   task automatic eg(input logic [9:0] s, input int n, input logic [63:0] e);
      wr(`TSQ_SCOPE_OFF, {22'h0, s});
      u_tsq_spi_host.xfer(`TSQ_Q_GERR, n);
      for (int i = 0; i < n; i++) `CHK(u_tsq_spi_host.rx[i], e[8*i +: 8])
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, mm} = '0;
      lk = 1'b1;
      num_errors = 0;
      total_checks = 0;
      cyc = 0;
      void'($urandom(32'h8b26));
      rst();
      rd(`TSQ_SCOPE_OFF);
      `CHK(q, 32'h0000_0000)
      rd(`TSQ_WINDOW_OFF);
      `CHK(q[15:0], 16'hBF40)
      rd(8'h18);
      `CHK({perr, q}, {1'b1, 32'h0000_0000})
      $display("test registers done");
      for (int i = 0; i < 64; i++) begin
         nv[i] = 8'($urandom);
         wr(`TSQ_NVWR_OFF, {16'h0, nv[i], 2'h0, 6'(i)});
      end
      rst();
      ck = fold();
      `CHK(q[15:8], ck)
      nv[9] = ~nv[9];
      wr(`TSQ_NVWR_OFF, {16'h0, nv[9], 8'h09});
      u_tsq_spi_host.xfer(`TSQ_Q_CSUM, 1);
      `CHK(u_tsq_spi_host.rx[0], ck)
      rst();
      u_tsq_spi_host.xfer(`TSQ_Q_CSUM, 1);
      `CHK(u_tsq_spi_host.rx[0], fold())
      $display("test checksum done");
      for (int i = 0; i < 64; i++) begin
         sg[i] = 8'($urandom);
         rf[i] = {1'b0, 7'($urandom)} + 8'h40;
         ld[i] = 8'($urandom);
         cz[i] = (i == 5) ? 8'h02 : {6'h0, 2'($urandom)};
         it[i] = 8'($urandom);
         kw(i, `TSQ_F_SIG, sg[i]);
         kw(i, `TSQ_F_REF, rf[i]);
         kw(i, `TSQ_F_LAD, ld[i]);
         kw(i, `TSQ_F_CZ, cz[i]);
         kw(i, `TSQ_F_INT, it[i]);
         kw(i, `TSQ_F_DET, 8'h00);
      end
      for (int i = 0; i < 4; i++) begin
         k = (i == 0) ? 5 : $urandom % 64;
         wr(`TSQ_SCOPE_OFF, 32'h0000_0100 | k);
         u_tsq_spi_host.xfer(`TSQ_Q_CZ, 1);
         `CHK(u_tsq_spi_host.rx[0], cz[k])
         u_tsq_spi_host.xfer(`TSQ_Q_INT, 1);
         `CHK(u_tsq_spi_host.rx[0], it[k])
      end
      grp(`TSQ_Q_GSIG, `TSQ_SC_ALL, 3'h0);
      grp(`TSQ_Q_GREF, `TSQ_SC_KEY, 3'h2);
      for (int c = 8'h20; c <= 8'h25; c++) begin
         x = 3'($urandom);
         grp(8'(c), `TSQ_SC_ROW, x);
         grp(8'(c), `TSQ_SC_COL, ~x);
      end
      $display("test queries done");
      kw(10, `TSQ_F_REF, 8'hBF);
      ek(10, 4'h0);
      kw(10, `TSQ_F_REF, 8'hC0);
      ek(10, 4'h4);
      kw(20, `TSQ_F_REF, 8'h40);
      ek(20, 4'h0);
      kw(20, `TSQ_F_REF, 8'h3F);
      ek(20, 4'h8);
      kw(10, `TSQ_F_RCST, 8'h00);
      ek(10, 4'h2);
      rd(`TSQ_STATUS_OFF);
      `CHK(q[2:1], 2'b11)
      repeat (4) kw(10, `TSQ_F_RCRES, 8'h00);
      ek(10, 4'h2);
      kw(10, `TSQ_F_RCRES, 8'h00);
      ek(10, 4'h1);
      kw(30, `TSQ_F_REF, 8'h48);
      kw(40, `TSQ_F_REF, 8'h60);
      wr(`TSQ_WINDOW_OFF, 32'h0000_5050);
      kw(30, `TSQ_F_RCST, 8'h00);
      kw(30, `TSQ_F_RCRES, 8'h01);
      ek(30, 4'h8);
      kw(40, `TSQ_F_RCST, 8'h00);
      kw(40, `TSQ_F_RCRES, 8'h01);
      ek(40, 4'h4);
      em = 64'h0000_0100_4010_0400;
      eg(10'h000, 8, em);
      // Row and column reports repeat their one bit map in every byte
      eg(10'h212, 8, 64'h0202_0202_0202_0202);
      eg(10'h31B, 8, 64'h4040_4040_4040_4040);
      eg(10'h10A, 1, 64'h0000_0000_0000_0001);
      $display("test errors done");
      kw(3, `TSQ_F_DET, 8'h01);
      for (int i = 0; i < 8; i++) begin
         wr(`TSQ_CTRL_OFF, {31'h0, i[0]});
         lk <= i[1];
         mm <= i[2];
         repeat (10) @(posedge pclk);
         rd(`TSQ_STATUS_OFF);
         `CHK(q[7:0], {3'h0, i[2], i[0] & ~i[1], 3'b101})
         u_tsq_spi_host.xfer(`TSQ_Q_STAT, 1);
         `CHK(u_tsq_spi_host.rx[0], {3'h0, i[2], i[0] & ~i[1], 3'b101})
      end
      $display("test status done");
      complete_run();
   end
endmodule

// [tb/tsq_checker.sv]
// Purpose: Port assertions for the status query responder
// Assumes: Bound to tsq_responder, one pclk domain
// Notes:   Async status inputs judged only once settled
`timescale 1ns/10ps
module tsq_checker (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [7:0]  paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        spi_cs_n,
   input logic        spi_miso,
   input logic        spi_miso_oe,
   input logic        sync_locked,
   input logic        nvm_mismatch
);
   logic       acc, map, stat, en_r, scw_r, lk_r, mm_r;
   logic [2:0] stab_r;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign acc  = psel && penable;
   assign map  = paddr[1:0] == 2'b00 && paddr <= 8'h14;
   assign stat = psel && !pwrite && paddr == 8'h10;
   // ----------------------------------------
   // Helper state
   // ----------------------------------------
   // Synchroniser delay: wait for inputs to rest before judging
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_r <= 1'b0;
         scw_r <= 1'b0;
         stab_r <= 3'h0;
      end else begin
         if (acc && pwrite && paddr == 8'h00) en_r <= pwdata[0];
         if (acc && pwrite && paddr == 8'h04) scw_r <= 1'b1;
         if (sync_locked != lk_r || nvm_mismatch != mm_r) stab_r <= 3'h0;
         else if (stab_r != 3'h7) stab_r <= stab_r + 3'h1;
      end
   end
   always_ff @(posedge pclk) begin
      lk_r <= sync_locked;
      mm_r <= nvm_mismatch;
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_ready_high: assert property (acc |-> pready)
      else $error("pready low in access phase");
   a_err_unmapped: assert property (acc && !map |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   a_ok_mapped: assert property (acc && map |-> !pslverr)
      else $error("error flagged on mapped access");
   a_stat_upper: assert property (stat |-> prdata[7:5] == 3'h0)
      else $error("status upper bits set");
   a_sync_fail: assert property (stat && stab_r == 3'h7 |->
      prdata[3] == (en_r && !sync_locked))
      else $error("sync fail bit wrong");
   a_nvm_flag: assert property (stat && stab_r == 3'h7 |-> prdata[4] == nvm_mismatch)
      else $error("mismatch bit wrong");
   a_scope_default: assert property (psel && !pwrite && paddr == 8'h04 && !scw_r |->
      prdata == 32'h0000_0000)
      else $error("scope not at default");
   a_oe_release: assert property ($rose(spi_cs_n) |-> ##[1:6] !spi_miso_oe)
      else $error("miso enable held after frame");
   a_miso_idle: assert property (spi_cs_n [*8] |-> !spi_miso && !spi_miso_oe)
      else $error("miso active outside frame");
   cover property (acc && !map);
   cover property (stat && prdata[3]);
   cover property ($fell(spi_cs_n));
endmodule
bind tsq_responder tsq_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
   .spi_miso_oe(spi_miso_oe), .sync_locked(sync_locked), .nvm_mismatch(nvm_mismatch));

// [tb/tsq_spi_host.sv]
// Purpose: Host side SPI master model
// Assumes: Mode 0, MSB first, 80 ns clock
// Notes:   Clock stands low between frames
`timescale 1ns/10ps
module tsq_spi_host (
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input  logic spi_miso
);
   logic [7:0] rx [$];
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // Command byte, one turnaround byte, then n answer bytes kept in rx
   // Answers trail by a byte: each one is loaded as a host byte completes
   task automatic xfer(input logic [7:0] cmd, input int n);
      logic [7:0] b;
      rx.delete();
      // Start 1 ns past a pclk edge so pin changes never race the sampler
      #81;
      spi_cs_n = 1'b0;
      #40;
      for (int k = 0; k <= n + 1; k++) begin
         for (int i = 7; i >= 0; i--) begin
            spi_mosi = (k == 0) ? cmd[i] : 1'b0;
            #40;
            spi_sclk = 1'b1;
            b[i] = spi_miso;
            #40;
            spi_sclk = 1'b0;
         end
         if (k > 1) rx.push_back(b);
      end
      #40;
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
   endtask
endmodule
